/* File: hdl/nvac_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the access controller
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define NVAC_OFS_CTRL      12'h18c
`define NVAC_OFS_UNLOCK    12'h190
`define NVAC_OFS_ADDR_LO   12'h1a0
`define NVAC_OFS_ADDR_HI   12'h1a4
`define NVAC_OFS_DATA_LO   12'h1a8
`define NVAC_OFS_DATA_HI   12'h1ac
`define NVAC_OFS_FLAG2     12'h1b0

// ==========================================================================
// Control register fields and the done bit of the flag register
`define NVAC_BIT_SPACE     7
`define NVAC_BIT_ABORT     3
`define NVAC_BIT_ALLOW     2
`define NVAC_BIT_WR        1
`define NVAC_BIT_RD        0
`define NVAC_BIT_DONE      4

// ==========================================================================
// Widths, keys, reset values and counts
`define NVAC_ADDR_HI_W     5
`define NVAC_DATA_HI_W     6
`define NVAC_KEY_FIRST     8'h55
`define NVAC_KEY_SECOND    8'haa
`define NVAC_RST_BYTE      8'h00
`define NVAC_RST_WORD      32'h0000_0000
`define NVAC_FLASH_RD_CYC  2
`define NVAC_WRITE_CYC     1000

`endif

/* File: hdl/nvac_pkg.sv */
// Purpose: Types shared by the access controller
// Assumes: Nothing
// Notes:   Constants live in nvac_cfg.svh
package nvac_pkg;

  // ========================================================================
  // Unlock key tracker
  typedef enum logic [1:0] {
    NVAC_KEY_IDLE,
    NVAC_KEY_GOT_FIRST,
    NVAC_KEY_ARMED
  } nvac_key_t;

endpackage

/* File: hdl/nvac_top.sv */
// Purpose: Access controller for data EEPROM and program FLASH, APB slave
// Assumes: Memories outside; EEPROM read data valid in the cycle of the address
// Notes:   One clock cycle stands for one instruction cycle
// Contract
// - Unlock port has no storage, reads zero, only takes the key bytes.
// - Space select zero routes operations to EEPROM, one to FLASH.
// - Read and write start are set only by software, cleared by hardware.
// - Write allow must be one for a write; cleared at power-up.
// - Abort flag set when master clear or watchdog cuts a write short.
// - Aborting reset keeps address, data and space select unchanged.
// - Write completion sets sticky done flag until software clears it.
// - EEPROM read data appears in low data register next cycle.
// - Low data register holds read value until next read or software write.
// - Write starts only after 55h then AAh to unlock port, then start.
// - Hardware never clears write allow.
// - Clearing write allow does not stop a running write.
// - Write start is blocked unless write allow is already one.
// - One control write setting allow and start together starts nothing.
// - FLASH read takes two cycles, word lands in high and low data.
// - High and low data hold FLASH word until next read or write.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_cfg.svh"

module nvac_top #(
  parameter int WRITE_CYCLES = `NVAC_WRITE_CYC,
  parameter int FLASH_RD_CYC = `NVAC_FLASH_RD_CYC,
  parameter int CNT_W        = 16
) (
  input  wire  logic        clock,
  input  wire  logic        rst,
  input  wire  logic        ce,
  input  wire  logic        master_clear_reset_abort,
  input  wire  logic        wdt_abort,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  output logic              mem_space,
  output logic [12:0]       mem_addr,
  output logic [13:0]       mem_wdata,
  input  wire  logic [13:0] mem_rdata,
  output logic              mem_rd,
  output logic              mem_wr_start,
  output logic              mem_wr_busy,
  output logic              mem_wr_abort,
  output logic              write_done_flag
);

  // ========================================================================
  // State
  logic                        space_reg;
  logic                        abort_reg;
  logic                        allow_reg;
  logic                        wr_reg;
  logic                        rd_reg;
  logic [7:0]                  addr_lo_reg;
  logic [`NVAC_ADDR_HI_W-1:0]  addr_hi_reg;
  logic [7:0]                  data_lo_reg;
  logic [`NVAC_DATA_HI_W-1:0]  data_hi_reg;
  logic                        done_reg;
  logic [CNT_W-1:0]            wr_cnt_reg;
  logic [1:0]                  rd_cnt_reg;
  nvac_pkg::nvac_key_t         key_reg;
  nvac_pkg::nvac_key_t         key_next;

  // ========================================================================
  // APB decode
  wire sel_ctl    = (paddr == `NVAC_OFS_CTRL);
  wire sel_unlock = (paddr == `NVAC_OFS_UNLOCK);
  wire sel_alo    = (paddr == `NVAC_OFS_ADDR_LO);
  wire sel_ahi    = (paddr == `NVAC_OFS_ADDR_HI);
  wire sel_dlo    = (paddr == `NVAC_OFS_DATA_LO);
  wire sel_dhi    = (paddr == `NVAC_OFS_DATA_HI);
  wire sel_flag   = (paddr == `NVAC_OFS_FLAG2);
  wire mapped     = sel_ctl | sel_unlock | sel_alo | sel_ahi | sel_dlo | sel_dhi | sel_flag;
  wire access     = psel & penable & ce;
  wire wr_acc     = access & pwrite & mapped;
  wire setup_rd   = psel & ~penable & ~pwrite & ce;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;

  // ========================================================================
  // Events
  wire abort_evt = (master_clear_reset_abort | wdt_abort) & ce;
  wire ctl_wr    = wr_acc & sel_ctl;
  wire unlock_wr = wr_acc & sel_unlock;
  // Start bits are set-only; old allow value gates write start
  wire wr_req    = ctl_wr & wbyte[`NVAC_BIT_WR] & ~wr_reg & ~rd_reg;
  wire wr_start  = wr_req & allow_reg & (key_reg == nvac_pkg::NVAC_KEY_ARMED) & ~abort_evt;
  wire rd_req    = ctl_wr & wbyte[`NVAC_BIT_RD] & ~wr_reg & ~rd_reg & ~abort_evt;
  wire ee_rd     = rd_req & ~space_reg;
  wire fl_rd     = rd_req & space_reg;
  wire fl_done   = rd_reg & ce & (rd_cnt_reg == 2'(FLASH_RD_CYC - 1)) & ~abort_evt;
  wire wr_done   = wr_reg & ce & (wr_cnt_reg == CNT_W'(1)) & ~abort_evt;
  wire wr_kill   = wr_reg & abort_evt;

  // ========================================================================
  // Unlock key sequence: any other write to a mapped register in between breaks it
  always_comb begin
    key_next = key_reg;
    if (abort_evt) begin
      key_next = nvac_pkg::NVAC_KEY_IDLE;
    end else if (wr_acc) begin
      unique case (key_reg)
        nvac_pkg::NVAC_KEY_IDLE: begin
          key_next = (unlock_wr && wbyte == `NVAC_KEY_FIRST) ?
                     nvac_pkg::NVAC_KEY_GOT_FIRST : nvac_pkg::NVAC_KEY_IDLE;
        end
        nvac_pkg::NVAC_KEY_GOT_FIRST: begin
          key_next = (unlock_wr && wbyte == `NVAC_KEY_SECOND) ?
                     nvac_pkg::NVAC_KEY_ARMED : nvac_pkg::NVAC_KEY_IDLE;
        end
        nvac_pkg::NVAC_KEY_ARMED: begin
          key_next = nvac_pkg::NVAC_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) key_reg <= nvac_pkg::NVAC_KEY_IDLE;
    else if (ce) key_reg <= key_next;
  end

  // ========================================================================
  // Control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      space_reg <= 1'b0;
      allow_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (ce) begin
      if (ctl_wr) begin
        space_reg <= wbyte[`NVAC_BIT_SPACE];
        allow_reg <= wbyte[`NVAC_BIT_ALLOW];
      end
      if (wr_kill) abort_reg <= 1'b1;
      else if (ctl_wr) abort_reg <= wbyte[`NVAC_BIT_ABORT];
    end
  end

  // Write start bit and write timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_reg     <= 1'b0;
      wr_cnt_reg <= '0;
    end else if (ce) begin
      if (wr_start) begin
        wr_reg     <= 1'b1;
        wr_cnt_reg <= CNT_W'(WRITE_CYCLES);
      end else if (wr_done || wr_kill) begin
        wr_reg     <= 1'b0;
        wr_cnt_reg <= '0;
      end else if (wr_reg) begin
        wr_cnt_reg <= wr_cnt_reg - CNT_W'(1);
      end
    end
  end

  // Read start bit and FLASH fetch counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_reg     <= 1'b0;
      rd_cnt_reg <= '0;
    end else if (ce) begin
      if (fl_rd) begin
        rd_reg     <= 1'b1;
        rd_cnt_reg <= '0;
      end else if (fl_done || abort_evt) begin
        rd_reg     <= 1'b0;
        rd_cnt_reg <= '0;
      end else if (rd_reg) begin
        rd_cnt_reg <= rd_cnt_reg + 2'h1;
      end
    end
  end

  // ========================================================================
  // Address and data registers, untouched by aborting resets
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_lo_reg <= `NVAC_RST_BYTE;
      addr_hi_reg <= '0;
      data_lo_reg <= `NVAC_RST_BYTE;
      data_hi_reg <= '0;
    end else if (ce) begin
      if (wr_acc && sel_alo) addr_lo_reg <= wbyte;
      if (wr_acc && sel_ahi) addr_hi_reg <= wbyte[`NVAC_ADDR_HI_W-1:0];
      if (ee_rd) begin
        data_lo_reg <= mem_rdata[7:0];
      end else if (fl_done) begin
        data_lo_reg <= mem_rdata[7:0];
        data_hi_reg <= mem_rdata[13:8];
      end else begin
        if (wr_acc && sel_dlo) data_lo_reg <= wbyte;
        if (wr_acc && sel_dhi) data_hi_reg <= wbyte[`NVAC_DATA_HI_W-1:0];
      end
    end
  end

  // Sticky write-done flag, set wins over software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) done_reg <= 1'b0;
    else if (ce) begin
      if (wr_done) done_reg <= 1'b1;
      else if (wr_acc && sel_flag) done_reg <= wbyte[`NVAC_BIT_DONE];
    end
  end

  // ========================================================================
  // Read data, captured in the setup cycle
  wire [7:0] ctl_byte = {space_reg, 3'h0, abort_reg, allow_reg, wr_reg, rd_reg};
  wire [7:0] rd_byte  = sel_ctl  ? ctl_byte :
                        sel_alo  ? addr_lo_reg :
                        sel_ahi  ? 8'({addr_hi_reg}) :
                        sel_dlo  ? data_lo_reg :
                        sel_dhi  ? 8'({data_hi_reg}) :
                        sel_flag ? 8'({done_reg, 4'h0}) :
                        `NVAC_RST_BYTE;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) prdata <= `NVAC_RST_WORD;
    else if (setup_rd) prdata <= {24'h00_0000, rd_byte};
  end

  // ========================================================================
  // Memory side
  assign mem_space       = space_reg;
  assign mem_addr        = {addr_hi_reg, addr_lo_reg};
  assign mem_wdata       = {data_hi_reg, data_lo_reg};
  assign mem_rd          = ee_rd | rd_reg;
  assign mem_wr_start    = wr_start;
  assign mem_wr_busy     = wr_reg;
  assign mem_wr_abort    = wr_kill;
  assign write_done_flag = done_reg;

  // ========================================================================
  // Checks
  logic [CNT_W-1:0] wr_age_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) wr_age_reg <= '0;
    else if (ce) wr_age_reg <= wr_reg ? wr_age_reg + CNT_W'(1) : '0;
  end

  sequence s_fl_fetch;
    rd_reg [*2];
  endsequence

  sequence s_fl_land;
    !rd_reg && data_lo_reg == $past(mem_rdata[7:0]) && data_hi_reg == $past(mem_rdata[13:8]);
  endsequence

  property p_unlock_zero;
    @(posedge clock) disable iff (rst) setup_rd && sel_unlock |=> prdata == 32'h0;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read not zero");

  property p_ee_read;
    @(posedge clock) disable iff (rst)
      ee_rd |=> !rd_reg && data_lo_reg == $past(mem_rdata[7:0]);
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("EEPROM read data late");

  property p_fl_read;
    @(posedge clock) disable iff (rst || !ce) fl_rd |=> s_fl_fetch ##1 s_fl_land;
  endproperty
  a_fl_read: assert property (p_fl_read) else $error("FLASH read timing wrong");

  property p_data_hold;
    @(posedge clock) disable iff (rst)
      !ee_rd && !fl_done && !(wr_acc && sel_dlo) |=> $stable(data_lo_reg);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("low data changed");

  property p_key_needed;
    @(posedge clock) disable iff (rst)
      $rose(wr_reg) |-> $past(key_reg) == nvac_pkg::NVAC_KEY_ARMED && $past(allow_reg);
  endproperty
  a_key_needed: assert property (p_key_needed) else $error("write began without key");

  property p_wr_time;
    @(posedge clock) disable iff (rst) wr_done |-> wr_age_reg == CNT_W'(WRITE_CYCLES - 1);
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write duration wrong");

  property p_done_set;
    @(posedge clock) disable iff (rst) wr_done |=> done_reg && !wr_reg;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_sticky;
    @(posedge clock) disable iff (rst) done_reg && !(wr_acc && sel_flag) |=> done_reg;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_allow_kept;
    @(posedge clock) disable iff (rst) allow_reg && !ctl_wr |=> allow_reg;
  endproperty
  a_allow_kept: assert property (p_allow_kept) else $error("write allow dropped");

  property p_abort;
    @(posedge clock) disable iff (rst) wr_kill |=> abort_reg && !wr_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag missing");

  property p_abort_keep;
    @(posedge clock) disable iff (rst)
      abort_evt && !wr_acc |=> $stable(space_reg) && $stable(mem_addr) && $stable(mem_wdata);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed registers");

  property p_wr_no_clear;
    @(posedge clock) disable iff (rst)
      wr_reg && ce && !wr_done && !abort_evt |=> wr_reg;
  endproperty
  a_wr_no_clear: assert property (p_wr_no_clear) else $error("write start cleared early");

  property p_rd_kept;
    @(posedge clock) disable iff (rst) rd_reg && ce && !fl_done && !abort_evt |=> rd_reg;
  endproperty
  a_rd_kept: assert property (p_rd_kept) else $error("read start cleared early");

  property p_no_start;
    @(posedge clock) disable iff (rst) wr_req && !allow_reg |=> !wr_reg;
  endproperty
  a_no_start: assert property (p_no_start) else $error("write began without allow");

  property p_ce_freeze;
    @(posedge clock) disable iff (rst)
      !ce |=> $stable(wr_reg) && $stable(wr_cnt_reg) && $stable(rd_reg) && $stable(key_reg);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

endmodule

`default_nettype wire

/* File: tb/test_nvac_top.sv */
// Purpose: Self-checking bench for the memory access controller over APB
// Assumes: Write duration shortened to 16 cycles; clock enable dropped once during a write
// Notes:   Memory model answers combinationally from the live address
`timescale 1ns/1ps
`default_nettype none
`include "nvac_cfg.svh"

module test_nvac_top;
  localparam int WC = 16;
  logic        clock, rst, ce, master_clear_reset_abort, wdt_abort;
  logic        psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        mem_space, mem_rd, mem_wr_start, mem_wr_busy, mem_wr_abort, write_done_flag;
  logic [12:0] mem_addr;
  logic [13:0] mem_wdata;
  wire  [13:0] mem_rdata;
  logic [7:0]  d, wd_seen;
  int          n_errors, comparisons, rd_cnt, busy_cnt, start_cnt, ab_cnt, i;

  // ==========================================================================
  // Memory model: EEPROM byte is address xor 5a, FLASH word is marker plus address
  assign mem_rdata = mem_space ? {1'b1, mem_addr} : {6'h00, mem_addr[7:0] ^ 8'h5a};

  nvac_top #(.WRITE_CYCLES(WC)) i_dut (
    .clock(clock), .rst(rst), .ce(ce), .master_clear_reset_abort(master_clear_reset_abort), .wdt_abort(wdt_abort),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
    .mem_wr_start(mem_wr_start), .mem_wr_busy(mem_wr_busy), .mem_wr_abort(mem_wr_abort),
    .write_done_flag(write_done_flag));

  // ==========================================================================
  // Clock, reset-free counters of strobe activity
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    if (mem_rd === 1'b1) rd_cnt++;
    if (mem_wr_busy === 1'b1) busy_cnt++;
    if (mem_wr_start === 1'b1) start_cnt++;
    if (mem_wr_start === 1'b1) wd_seen = mem_wdata[7:0];
    if (mem_wr_abort === 1'b1) ab_cnt++;
  end

  // ==========================================================================
  // APB master tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    d = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string m);
    apb(1'b0, a, 8'h00);
    chk(d, exp, m);
  endtask

  task automatic key_start(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    apb(1'b1, `NVAC_OFS_UNLOCK, k1);
    apb(1'b1, `NVAC_OFS_UNLOCK, k2);
    apb(1'b1, `NVAC_OFS_CTRL, c);
  endtask

  task automatic wait_idle();
    for (i = 0; i < 100 && mem_wr_busy !== 1'b0; i++) @(posedge clock);
  endtask

  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #160000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1; ce = 1'b1; master_clear_reset_abort = 1'b0; wdt_abort = 1'b0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h00000000;
    n_errors = 0; comparisons = 0; rd_cnt = 0; busy_cnt = 0; start_cnt = 0; ab_cnt = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdchk(`NVAC_OFS_CTRL, 8'h00, "control after reset");
    apb(1'b1, `NVAC_OFS_UNLOCK, 8'h55);
    rdchk(`NVAC_OFS_UNLOCK, 8'h00, "unlock port reads zero");
    rdchk(12'h000, 8'h00, "unmapped read");
    chk({7'h00, last_err}, 8'h01, "unmapped error");
    $display("test reset done");

    apb(1'b1, `NVAC_OFS_ADDR_LO, 8'h3c);
    apb(1'b1, `NVAC_OFS_CTRL, 8'h01);
    rdchk(`NVAC_OFS_DATA_LO, 8'h66, "eeprom read data");
    chk(rd_cnt[7:0], 8'h01, "eeprom fetch cycles");
    apb(1'b1, `NVAC_OFS_ADDR_LO, 8'h10);
    rdchk(`NVAC_OFS_DATA_LO, 8'h66, "eeprom data held");
    $display("test eeprom read done");

    apb(1'b1, `NVAC_OFS_ADDR_HI, 8'h15);
    apb(1'b1, `NVAC_OFS_CTRL, 8'h80);
    rd_cnt = 0;
    apb(1'b1, `NVAC_OFS_CTRL, 8'h81);
    repeat (2) @(posedge clock);
    chk(rd_cnt[7:0], 8'h02, "flash fetch cycles");
    rdchk(`NVAC_OFS_DATA_LO, 8'h10, "flash low byte");
    rdchk(`NVAC_OFS_DATA_HI, 8'h35, "flash high byte");
    apb(1'b1, `NVAC_OFS_ADDR_LO, 8'h77);
    rdchk(`NVAC_OFS_DATA_LO, 8'h10, "flash word held");
    apb(1'b1, `NVAC_OFS_CTRL, 8'h00);
    $display("test flash read done");

    key_start(8'h55, 8'haa, 8'h06);
    chk(start_cnt[7:0], 8'h00, "allow and start together");
    rdchk(`NVAC_OFS_CTRL, 8'h04, "allow only");
    key_start(8'haa, 8'h55, 8'h06);
    rdchk(`NVAC_OFS_CTRL, 8'h04, "keys reversed");
    apb(1'b1, `NVAC_OFS_UNLOCK, 8'h55);
    key_start(8'haa, 8'h00, 8'h06);
    rdchk(`NVAC_OFS_CTRL, 8'h04, "key broken by write");
    apb(1'b1, `NVAC_OFS_CTRL, 8'h00);
    key_start(8'h55, 8'haa, 8'h02);
    rdchk(`NVAC_OFS_CTRL, 8'h00, "start without allow");
    chk(start_cnt[7:0], 8'h00, "no start strobe");
    $display("test refused writes done");

    apb(1'b1, `NVAC_OFS_DATA_LO, 8'hc3);
    apb(1'b1, `NVAC_OFS_CTRL, 8'h04);
    busy_cnt = 0;
    key_start(8'h55, 8'haa, 8'h06);
    rdchk(`NVAC_OFS_CTRL, 8'h06, "write running");
    apb(1'b1, `NVAC_OFS_CTRL, 8'h04);
    rdchk(`NVAC_OFS_CTRL, 8'h06, "start not clearable");
    rdchk(`NVAC_OFS_FLAG2, 8'h00, "done clear while busy");
    wait_idle();
    chk(busy_cnt[7:0], WC[7:0], "write duration");
    chk(wd_seen, 8'hc3, "write data to memory");
    rdchk(`NVAC_OFS_CTRL, 8'h04, "allow kept after write");
    rdchk(`NVAC_OFS_FLAG2, 8'h10, "done flag set");
    chk({7'h00, write_done_flag}, 8'h01, "done pin");
    rdchk(`NVAC_OFS_FLAG2, 8'h10, "done flag sticky");
    apb(1'b1, `NVAC_OFS_FLAG2, 8'h00);
    rdchk(`NVAC_OFS_FLAG2, 8'h00, "done flag cleared");
    busy_cnt = 0;
    key_start(8'h55, 8'haa, 8'h06);
    apb(1'b1, `NVAC_OFS_CTRL, 8'h00);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    wait_idle();
    chk(busy_cnt[7:0], 8'(WC + 3), "write survives allow clear and freeze");
    chk(start_cnt[7:0], 8'h02, "start strobes");
    rdchk(`NVAC_OFS_FLAG2, 8'h10, "second done");
    apb(1'b1, `NVAC_OFS_FLAG2, 8'h00);
    $display("test data write done");

    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `NVAC_OFS_CTRL, 8'h04);
      key_start(8'h55, 8'haa, 8'h06);
      if (k == 0) master_clear_reset_abort <= 1'b1;
      else wdt_abort <= 1'b1;
      @(posedge clock);
      master_clear_reset_abort <= 1'b0;
      wdt_abort <= 1'b0;
      @(posedge clock);
      rdchk(`NVAC_OFS_CTRL, 8'h0c, "abort flag");
      rdchk(`NVAC_OFS_ADDR_LO, 8'h77, "address kept");
      rdchk(`NVAC_OFS_DATA_LO, 8'hc3, "data kept");
      rdchk(`NVAC_OFS_FLAG2, 8'h00, "no done on abort");
    end
    chk(ab_cnt[7:0], 8'h02, "abort strobes");
    $display("test abort done");
    test_done();
  end
endmodule

`default_nettype wire
